// ---- verilog/shc_top.sv ----
// Contract
// - controller active only on ports 1, 8, 9 configured downstream
// - insertion sets presence state and changed; removal clears state, sets changed
// - latch state bit reads 0 closed, 1 open
// - any latch state change sets latch changed flag
// - latch change raises interrupt message when enabled
// - attention button press sets pressed flag
// - button press raises interrupt message when enabled
// - deassert message sent once the causing flag is cleared
// - blink request stores 10b, sets command completed, interrupts if enabled
// - power control cleared powers slot; completed after power-to-valid delay
// - power-on completion raises interrupt when enabled
// - indicator on request stores 01b, completes, asserts interrupt if enabled
// - link active flag reported at 78h bit 29
// - power-off completes 256 ms after slot power removed
// - power-off completion raises interrupt when enabled
// - indicator off request stores 00b and sets command completed
// - latch and button levels taken only after 10 ms stable
// - power enable, then refclk after power-to-valid delay, 16 ms default
// - power-down: reset, refclk off 100 us later, power off 100 us later
module shc_top
	import shc_pkg::*;
#(
	parameter int unsigned PORT_NUM = HP_PORT_A,
	parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_CYC_DEF,
	parameter int unsigned TPEPV_CYC = TPEPV_CYC_DEF,
	parameter int unsigned TPEPV_ALT_CYC = TPEPV_ALT_CYC_DEF,
	parameter int unsigned TPVPERL_CYC = TPVPERL_CYC_DEF,
	parameter int unsigned STEP_CYC = STEP_CYC_DEF,
	parameter int unsigned OFF_WAIT_CYC = OFF_WAIT_CYC_DEF,
	parameter int unsigned BLINK_CYC = BLINK_CYC_DEF
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic port_downstream_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	input wire logic slot_present_n_i,
	input wire logic slot_latch_sense_n_i,
	input wire logic slot_button_n_i,
	input wire logic link_active_i,
	output logic slot_power_on_n_o,
	output logic slot_refclk_on_n_o,
	output logic slot_reset_n_o,
	output logic slot_power_lamp_n_o,
	output logic intx_assert_o,
	output logic intx_deassert_o
);
	localparam bit HP_CAPABLE = PORT_NUM == HP_PORT_A || PORT_NUM == HP_PORT_B
		|| PORT_NUM == HP_PORT_C;
	localparam int CH_PRES = 0;
	localparam int CH_LATCH = 1;
	localparam int CH_BTN = 2;

	if (TPEPV_CYC == 0 || TPEPV_ALT_CYC == 0 || TPVPERL_CYC == 0 || STEP_CYC == 0
		|| OFF_WAIT_CYC == 0 || BLINK_CYC == 0) begin : g_chk
		$error("shc_top: every delay count must be nonzero");
	end

	logic strap_taken_q;
	logic hp_en_q;
	logic [2:0] pins;
	logic [2:0] lvl;
	logic [2:0] lvl_prev_q;
	logic pres_evt;
	logic latch_evt;
	logic btn_evt;
	logic [5:0] ctrl_en_q;
	logic [1:0] ind_q;
	logic ppc_q;
	logic [1:0] cfg_tpepv_q;
	logic abp_q;
	logic mrlc_q;
	logic pdc_q;
	logic cc_q;
	logic slot_wr;
	logic cfg_wr;
	logic seq_idle;
	logic cmd_ok;
	logic [1:0] ind_new;
	logic ind_cmd;
	logic pwr_cmd;
	logic ind_done_q;
	logic seq_done_q;
	shc_seq_t seq_q;
	logic tmr_load_q;
	logic [TMR_W-1:0] tmr_val_q;
	logic tmr_done;
	logic [TMR_W-1:0] tpepv_cyc;
	logic irq_pend;
	logic irq_pend_q;
	logic [TMR_W-1:0] blink_cnt_q;
	logic blink_ph_q;
	logic [DATA_W-1:0] rd_slot;
	logic [DATA_W-1:0] rd_link;
	logic [DATA_W-1:0] rd_cfg;

	// port role taken once after reset release
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			strap_taken_q <= 1'b0;
			hp_en_q <= 1'b0;
		end
		else if (!strap_taken_q)
		begin
			strap_taken_q <= 1'b1;
			hp_en_q <= HP_CAPABLE && port_downstream_i;
		end
	end

	assign pins = {slot_button_n_i, slot_latch_sense_n_i, slot_present_n_i};

	for (genvar i = 0; i < 3; i++) begin : g_deb
		shc_debounce #(
			.STABLE_CYC(DEBOUNCE_CYC),
			.RESET_LEVEL(1'b1)
		) u_deb (
			.core_clk_i(core_clk_i),
			.sys_rst_i(sys_rst_i),
			.pin_i(pins[i]),
			.level_o(lvl[i])
		);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			lvl_prev_q <= 3'h7;
		else
			lvl_prev_q <= lvl;
	end

	assign pres_evt = hp_en_q && lvl[CH_PRES] != lvl_prev_q[CH_PRES];
	assign latch_evt = hp_en_q && lvl[CH_LATCH] != lvl_prev_q[CH_LATCH];
	assign btn_evt = hp_en_q && !lvl[CH_BTN] && lvl_prev_q[CH_BTN];

	assign slot_wr = reg_wr_i && reg_addr_i == OFF_SLOT;
	assign cfg_wr = reg_wr_i && reg_addr_i == OFF_HP_CFG;
	assign seq_idle = seq_q == SEQ_OFF || seq_q == SEQ_ON;
	assign cmd_ok = hp_en_q && !cc_q && seq_idle;
	assign ind_new = reg_wdata_i[CT_IND_LO +: 2];
	assign ind_cmd = slot_wr && cmd_ok && ind_new != ind_q;
	assign pwr_cmd = slot_wr && cmd_ok && reg_wdata_i[CT_PPC] != ppc_q;

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			ctrl_en_q <= CT_EN_RST;
		else if (slot_wr)
			ctrl_en_q <= reg_wdata_i[CT_EN_LO +: 6] & CT_EN_MASK;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			cfg_tpepv_q <= CFG_TPEPV_RST;
		else if (cfg_wr)
			cfg_tpepv_q <= reg_wdata_i[CFG_TPEPV_LO +: 2];
	end

	// indicator field holds the code of the last accepted command
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			ind_q <= IND_OFF;
		else if (ind_cmd)
			ind_q <= ind_new;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			ppc_q <= CT_PPC_RST;
		else if (pwr_cmd)
			ppc_q <= reg_wdata_i[CT_PPC];
	end

	// indicator-only commands complete on the next edge
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			ind_done_q <= 1'b0;
		else
			ind_done_q <= ind_cmd && !pwr_cmd;
	end

	// status flags: hardware set wins over a same-cycle clear
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			pdc_q <= 1'b0;
		else if (pres_evt)
			pdc_q <= 1'b1;
		else if (slot_wr && reg_wdata_i[ST_PDC])
			pdc_q <= 1'b0;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			mrlc_q <= 1'b0;
		else if (latch_evt)
			mrlc_q <= 1'b1;
		else if (slot_wr && reg_wdata_i[ST_MRLC])
			mrlc_q <= 1'b0;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			abp_q <= 1'b0;
		else if (btn_evt)
			abp_q <= 1'b1;
		else if (slot_wr && reg_wdata_i[ST_ABP])
			abp_q <= 1'b0;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			cc_q <= 1'b0;
		else if (ind_done_q || seq_done_q)
			cc_q <= 1'b1;
		else if (slot_wr && reg_wdata_i[ST_CC])
			cc_q <= 1'b0;
	end

	assign tpepv_cyc = cfg_tpepv_q == CFG_TPEPV_RST ? TMR_W'(TPEPV_CYC)
		: TMR_W'(TPEPV_ALT_CYC);

	shc_timer u_tmr (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.load_i(tmr_load_q),
		.value_i(tmr_val_q),
		.done_o(tmr_done)
	);

	// slot power sequencer; pins are active low
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			seq_q <= SEQ_OFF;
			seq_done_q <= 1'b0;
			tmr_load_q <= 1'b0;
			tmr_val_q <= '0;
			slot_power_on_n_o <= 1'b1;
			slot_refclk_on_n_o <= 1'b1;
			slot_reset_n_o <= 1'b0;
		end
		else
		begin
			seq_done_q <= 1'b0;
			tmr_load_q <= 1'b0;
			unique case (seq_q)
				SEQ_OFF:
					if (pwr_cmd && !reg_wdata_i[CT_PPC])
					begin
						slot_power_on_n_o <= 1'b0;
						tmr_load_q <= 1'b1;
						tmr_val_q <= tpepv_cyc;
						seq_q <= SEQ_UP_PWR;
					end
				SEQ_UP_PWR:
					if (tmr_done)
					begin
						slot_refclk_on_n_o <= 1'b0;
						seq_done_q <= 1'b1;
						tmr_load_q <= 1'b1;
						tmr_val_q <= TMR_W'(TPVPERL_CYC);
						seq_q <= SEQ_UP_CLK;
					end
				SEQ_UP_CLK:
					if (tmr_done)
					begin
						slot_reset_n_o <= 1'b1;
						seq_q <= SEQ_ON;
					end
				SEQ_ON:
					if (pwr_cmd && reg_wdata_i[CT_PPC])
					begin
						slot_reset_n_o <= 1'b0;
						tmr_load_q <= 1'b1;
						tmr_val_q <= TMR_W'(STEP_CYC);
						seq_q <= SEQ_DN_RST;
					end
				SEQ_DN_RST:
					if (tmr_done)
					begin
						slot_refclk_on_n_o <= 1'b1;
						tmr_load_q <= 1'b1;
						tmr_val_q <= TMR_W'(STEP_CYC);
						seq_q <= SEQ_DN_CLK;
					end
				SEQ_DN_CLK:
					if (tmr_done)
					begin
						slot_power_on_n_o <= 1'b1;
						tmr_load_q <= 1'b1;
						tmr_val_q <= TMR_W'(OFF_WAIT_CYC);
						seq_q <= SEQ_DN_WAIT;
					end
				SEQ_DN_WAIT:
					if (tmr_done)
					begin
						seq_done_q <= 1'b1;
						seq_q <= SEQ_OFF;
					end
				default:
					seq_q <= SEQ_OFF;
			endcase
		end
	end

	// level interrupt turned into assert and deassert messages
	assign irq_pend = ctrl_en_q[CT_HPI_EN] && (
		(pdc_q && ctrl_en_q[CT_PDC_EN])
		|| (mrlc_q && ctrl_en_q[CT_MRL_EN])
		|| (abp_q && ctrl_en_q[CT_ABP_EN])
		|| (cc_q && ctrl_en_q[CT_CC_EN]));

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			irq_pend_q <= 1'b0;
			intx_assert_o <= 1'b0;
			intx_deassert_o <= 1'b0;
		end
		else
		begin
			irq_pend_q <= irq_pend;
			intx_assert_o <= irq_pend && !irq_pend_q;
			intx_deassert_o <= !irq_pend && irq_pend_q;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i || ind_q != IND_BLINK)
		begin
			blink_cnt_q <= '0;
			blink_ph_q <= 1'b0;
		end
		else if (blink_cnt_q == TMR_W'(BLINK_CYC - 1))
		begin
			blink_cnt_q <= '0;
			blink_ph_q <= !blink_ph_q;
		end
		else
			blink_cnt_q <= blink_cnt_q + 1'b1;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			slot_power_lamp_n_o <= 1'b1;
		else if (ind_q == IND_ON)
			slot_power_lamp_n_o <= 1'b0;
		else if (ind_q == IND_BLINK)
			slot_power_lamp_n_o <= blink_ph_q;
		else
			slot_power_lamp_n_o <= 1'b1;
	end

	always_comb
	begin
		rd_slot = '0;
		rd_slot[CT_EN_LO +: 6] = ctrl_en_q;
		rd_slot[CT_IND_LO +: 2] = ind_q;
		rd_slot[CT_PPC] = ppc_q;
		rd_slot[ST_ABP] = abp_q;
		rd_slot[ST_MRLC] = mrlc_q;
		rd_slot[ST_PDC] = pdc_q;
		rd_slot[ST_CC] = cc_q;
		rd_slot[ST_MRLS] = lvl[CH_LATCH];
		rd_slot[ST_PDS] = !lvl[CH_PRES];
		rd_link = '0;
		rd_link[BIT_DLL_ACTIVE] = link_active_i;
		rd_cfg = '0;
		rd_cfg[CFG_TPEPV_LO +: 2] = cfg_tpepv_q;
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i || !reg_rd_i)
			reg_rdata_o <= '0;
		else if (reg_addr_i == OFF_SLOT)
			reg_rdata_o <= rd_slot;
		else if (reg_addr_i == OFF_LINK_STAT)
			reg_rdata_o <= rd_link;
		else if (reg_addr_i == OFF_HP_CFG)
			reg_rdata_o <= rd_cfg;
		else
			reg_rdata_o <= '0;
	end
endmodule : shc_top

// ---- verilog/shc_pkg.sv ----
package shc_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int TMR_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_LINK_STAT = 12'h078;
	localparam logic [ADDR_W-1:0] OFF_SLOT = 12'h080;
	localparam logic [ADDR_W-1:0] OFF_HP_CFG = 12'h1E0;

	// field positions
	localparam int BIT_DLL_ACTIVE = 29;
	localparam int CT_EN_LO = 0;
	localparam int CT_ABP_EN = 0;
	localparam int CT_MRL_EN = 2;
	localparam int CT_PDC_EN = 3;
	localparam int CT_CC_EN = 4;
	localparam int CT_HPI_EN = 5;
	localparam int CT_IND_LO = 8;
	localparam int CT_PPC = 10;
	localparam int ST_ABP = 16;
	localparam int ST_MRLC = 18;
	localparam int ST_PDC = 19;
	localparam int ST_CC = 20;
	localparam int ST_MRLS = 21;
	localparam int ST_PDS = 22;
	localparam int CFG_TPEPV_LO = 3;

	// writable enables; bit 1 has no source here
	localparam logic [5:0] CT_EN_MASK = 6'h3D;
	localparam logic [5:0] CT_EN_RST = 6'h00;
	localparam logic CT_PPC_RST = 1'b1;
	localparam logic [1:0] CFG_TPEPV_RST = 2'h0;

	// indicator codes
	localparam logic [1:0] IND_OFF = 2'h0;
	localparam logic [1:0] IND_ON = 2'h1;
	localparam logic [1:0] IND_BLINK = 2'h2;

	// hot plug capable ports
	localparam int HP_PORT_A = 1;
	localparam int HP_PORT_B = 8;
	localparam int HP_PORT_C = 9;

	// timing
	localparam int CLK_MHZ = 100;
	localparam int DEBOUNCE_MS = 10;
	localparam int TPEPV_MS = 16;
	localparam int TPEPV_ALT_MS = 32;
	localparam int TPVPERL_MS = 100;
	localparam int STEP_US = 100;
	localparam int OFF_WAIT_MS = 256;
	localparam int BLINK_MS = 500;
	localparam int DEBOUNCE_CYC_DEF = DEBOUNCE_MS * 1000 * CLK_MHZ;
	localparam int TPEPV_CYC_DEF = TPEPV_MS * 1000 * CLK_MHZ;
	localparam int TPEPV_ALT_CYC_DEF = TPEPV_ALT_MS * 1000 * CLK_MHZ;
	localparam int TPVPERL_CYC_DEF = TPVPERL_MS * 1000 * CLK_MHZ;
	localparam int STEP_CYC_DEF = STEP_US * CLK_MHZ;
	localparam int OFF_WAIT_CYC_DEF = OFF_WAIT_MS * 1000 * CLK_MHZ;
	localparam int BLINK_CYC_DEF = BLINK_MS * 1000 * CLK_MHZ;

	typedef enum logic [6:0] {
		SEQ_OFF = 7'b000_0001,
		SEQ_UP_PWR = 7'b000_0010,
		SEQ_UP_CLK = 7'b000_0100,
		SEQ_ON = 7'b000_1000,
		SEQ_DN_RST = 7'b001_0000,
		SEQ_DN_CLK = 7'b010_0000,
		SEQ_DN_WAIT = 7'b100_0000
	} shc_seq_t;
endpackage : shc_pkg

// ---- verilog/shc_debounce.sv ----
module shc_debounce
	import shc_pkg::*;
#(
	parameter int unsigned STABLE_CYC = DEBOUNCE_CYC_DEF,
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	output logic level_o
);
	logic [2:0] sync_q;
	logic [TMR_W-1:0] cnt_q;

	if (STABLE_CYC == 0) begin : g_chk
		$error("shc_debounce: STABLE_CYC must be nonzero");
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			sync_q <= {3{RESET_LEVEL}};
		else
			sync_q <= {sync_q[1:0], pin_i};
	end

	// new level is taken only after it held for the whole window
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			cnt_q <= '0;
			level_o <= RESET_LEVEL;
		end
		else if (sync_q[1] == sync_q[2] && sync_q[2] != level_o)
		begin
			if (cnt_q == TMR_W'(STABLE_CYC - 1))
			begin
				cnt_q <= '0;
				level_o <= sync_q[2];
			end
			else
				cnt_q <= cnt_q + 1'b1;
		end
		else
			cnt_q <= '0;
	end
endmodule : shc_debounce

// ---- verilog/shc_timer.sv ----
module shc_timer
	import shc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic load_i,
	input wire logic [TMR_W-1:0] value_i,
	output logic done_o
);
	logic [TMR_W-1:0] cnt_q;

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			cnt_q <= '0;
		else if (load_i)
			cnt_q <= value_i;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	// one-cycle pulse as the count runs out
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			done_o <= 1'b0;
		else
			done_o <= !load_i && cnt_q == TMR_W'(1);
	end
endmodule : shc_timer

// ---- verif/shc_top_assertions.sv ----
module shc_top_assertions
	import shc_pkg::*;
#(
	parameter int unsigned TPEPV_CYC = TPEPV_CYC_DEF,
	parameter int unsigned STEP_CYC = STEP_CYC_DEF
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	input wire logic link_active_i,
	input wire logic slot_power_on_n_o,
	input wire logic slot_refclk_on_n_o,
	input wire logic slot_reset_n_o,
	input wire logic intx_assert_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int UP_LO = TPEPV_CYC - 2;
	localparam int UP_HI = TPEPV_CYC + 6;
	localparam int DN_LO = STEP_CYC - 2;
	localparam int DN_HI = STEP_CYC + 6;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// power-down begins with slot reset while the clock still runs
	sequence s_dn_start;
		$fell(slot_reset_n_o) ##0 !slot_refclk_on_n_o;
	endsequence
	sequence s_dn_clk;
		s_dn_start ##[DN_LO:DN_HI] $rose(slot_refclk_on_n_o);
	endsequence
	property p_rdata_idle;
		!reg_rd_i |=> reg_rdata_o == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_link_bit;
		reg_rd_i && reg_addr_i == OFF_LINK_STAT |=> reg_rdata_o[BIT_DLL_ACTIVE] == $past(link_active_i);
	endproperty
	a_link_bit: assert property (p_link_bit) else $error("link flag wrong");
	property p_up_order;
		$fell(slot_refclk_on_n_o) |-> !slot_power_on_n_o;
	endproperty
	a_up_order: assert property (p_up_order) else $error("refclk before power");
	property p_up_delay;
		$fell(slot_power_on_n_o) |-> ##[UP_LO:UP_HI] $fell(slot_refclk_on_n_o);
	endproperty
	a_up_delay: assert property (p_up_delay) else $error("power valid delay wrong");
	property p_rst_held;
		$fell(slot_refclk_on_n_o) |-> !slot_reset_n_o [*8];
	endproperty
	a_rst_held: assert property (p_rst_held) else $error("slot reset released early");
	property p_dn_clk;
		s_dn_start |-> ##[DN_LO:DN_HI] $rose(slot_refclk_on_n_o);
	endproperty
	a_dn_clk: assert property (p_dn_clk) else $error("refclk off step wrong");
	property p_dn_pwr;
		s_dn_clk |-> ##[DN_LO:DN_HI] $rose(slot_power_on_n_o);
	endproperty
	a_dn_pwr: assert property (p_dn_pwr) else $error("power off step wrong");
	property p_int_pulse;
		intx_assert_o |=> !intx_assert_o;
	endproperty
	a_int_pulse: assert property (p_int_pulse) else $error("assert message too long");
endmodule : shc_top_assertions

// ---- verif/shc_slot_model.sv ----
module shc_slot_model #(
	parameter int unsigned TRAIN_CYC = 4
) (
	input wire logic core_clk_i,
	input wire logic card_in_i,
	input wire logic latch_closed_i,
	input wire logic press_i,
	input wire logic slot_power_on_n_i,
	input wire logic slot_refclk_on_n_i,
	input wire logic slot_reset_n_i,
	output logic slot_present_n_o,
	output logic slot_latch_sense_n_o,
	output logic slot_button_n_o,
	output logic link_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int train_q = 0;
	assign slot_present_n_o = !card_in_i;
	assign slot_latch_sense_n_o = !latch_closed_i;
	assign slot_button_n_o = !press_i;
	// link trains only on a powered, clocked card out of reset
	always_ff @(posedge core_clk_i)
	begin
		if (!card_in_i || slot_power_on_n_i || slot_refclk_on_n_i || !slot_reset_n_i)
			train_q <= 0;
		else if (train_q < TRAIN_CYC)
			train_q <= train_q + 1;
	end
	assign link_active_o = (train_q == TRAIN_CYC);
endmodule : shc_slot_model

// ---- verif/shc_top_tb.sv ----
module shc_top_tb
	import shc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] EN = 32'h0000_003D;
	localparam int unsigned T_DEB = 20;
	localparam int unsigned T_PV = 50;
	localparam int unsigned T_PERL = 30;
	localparam int unsigned T_STEP = 10;
	localparam int unsigned T_OFF = 40;
	localparam int unsigned T_BLINK = 8;
	logic down = 1'b1;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic card = 1'b0;
	logic latch = 1'b0;
	logic press = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic pres_n, latch_n, btn_n, link_act, pwr_n, clk_n, rst_n, lamp_n, int_as, int_ds;
	logic [31:0] ctl_q = 32'h0000_043D;
	int fail_count = 0;
	int tests_run = 0;
	int as_cnt = 0;
	int ds_cnt = 0;
	shc_top #(.DEBOUNCE_CYC(T_DEB), .TPEPV_CYC(T_PV), .TPVPERL_CYC(T_PERL),
		.STEP_CYC(T_STEP), .OFF_WAIT_CYC(T_OFF), .BLINK_CYC(T_BLINK)) u_dut (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.port_downstream_i(down),
		.reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd),
		.reg_rdata_o(rdata),
		.slot_present_n_i(pres_n),
		.slot_latch_sense_n_i(latch_n),
		.slot_button_n_i(btn_n),
		.link_active_i(link_act),
		.slot_power_on_n_o(pwr_n),
		.slot_refclk_on_n_o(clk_n),
		.slot_reset_n_o(rst_n),
		.slot_power_lamp_n_o(lamp_n),
		.intx_assert_o(int_as),
		.intx_deassert_o(int_ds)
	);
	shc_slot_model u_slot (
		.core_clk_i(core_clk_i),
		.card_in_i(card),
		.latch_closed_i(latch),
		.press_i(press),
		.slot_power_on_n_i(pwr_n),
		.slot_refclk_on_n_i(clk_n),
		.slot_reset_n_i(rst_n),
		.slot_present_n_o(pres_n),
		.slot_latch_sense_n_o(latch_n),
		.slot_button_n_o(btn_n),
		.link_active_o(link_act)
	);
	initial
	begin
		forever #5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i)
	begin
		if (int_as === 1'b1)
			as_cnt++;
		if (int_ds === 1'b1)
			ds_cnt++;
	end
	task automatic chk(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk_i);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] m, e, input string what);
		@(posedge core_clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk_i);
		reg_rd <= 1'b0;
		@(negedge core_clk_i);
		chk(what, rdata & m, e);
	endtask : rd_chk
	task automatic pins(input logic c, l, p);
		@(posedge core_clk_i);
		card <= c;
		latch <= l;
		press <= p;
	endtask : pins
	task automatic wait_cnt(ref int c, input int n);
		for (int i = 0; i < 500 && c < n; i++)
			@(posedge core_clk_i);
	endtask : wait_cnt
	// event seen, message sent, flag cleared by software, deassert sent
	task automatic ev_flow(input int flag, input logic [31:0] m, e, input string what);
		int a;
		int d;
		a = as_cnt + 1;
		d = ds_cnt + 1;
		wait_cnt(as_cnt, a);
		chk({what, " int"}, as_cnt, a);
		rd_chk(OFF_SLOT, m | (32'h1 << flag), e | (32'h1 << flag), what);
		wr(OFF_SLOT, ctl_q | (32'h1 << flag));
		wait_cnt(ds_cnt, d);
		chk({what, " deassert"}, ds_cnt, d);
		rd_chk(OFF_SLOT, 32'h1 << flag, 32'h0, {what, " clear"});
	endtask : ev_flow
	task automatic cmd(input logic [1:0] ind, input logic ppc, input string what);
		ctl_q = EN | (32'(ind) << CT_IND_LO) | (32'(ppc) << CT_PPC);
		wr(OFF_SLOT, ctl_q);
		ev_flow(ST_CC, 32'h0000_0700, ctl_q & 32'h0000_0700, what);
	endtask : cmd
	task automatic t_reset;
		chk("pins reset", {pwr_n, clk_n, rst_n, lamp_n}, 32'h0000_000D);
		rd_chk(OFF_SLOT, 32'hFFDF_FFFF, 32'h0000_0400, "slot reset");
		rd_chk(OFF_LINK_STAT, 32'hFFFF_FFFF, 32'h0, "link reset");
		rd_chk(12'h100, 32'hFFFF_FFFF, 32'h0, "unmapped");
		wr(OFF_HP_CFG, 32'h0000_0018);
		rd_chk(OFF_HP_CFG, 32'h0000_0018, 32'h0000_0018, "cfg");
		wr(OFF_HP_CFG, 32'h0);
		wr(OFF_SLOT, ctl_q);
	endtask : t_reset
	task automatic t_insert;
		pins(1'b1, 1'b0, 1'b0);
		ev_flow(ST_PDC, 32'h1 << ST_PDS, 32'h1 << ST_PDS, "insert");
	endtask : t_insert
	task automatic t_latch;
		pins(1'b1, 1'b1, 1'b0);
		ev_flow(ST_MRLC, 32'h1 << ST_MRLS, 32'h0, "latch close");
	endtask : t_latch
	task automatic t_button;
		pins(1'b1, 1'b1, 1'b1);
		ev_flow(ST_ABP, 32'h0, 32'h0, "button");
		pins(1'b1, 1'b1, 1'b0);
	endtask : t_button
	task automatic t_power_up;
		logic l;
		cmd(IND_BLINK, 1'b1, "blink");
		l = lamp_n;
		repeat (T_BLINK) @(negedge core_clk_i);
		chk("blink lamp", lamp_n, !l);
		ctl_q = EN | (32'(IND_BLINK) << CT_IND_LO);
		wr(OFF_SLOT, ctl_q);
		wr(OFF_SLOT, EN | (32'(IND_ON) << CT_IND_LO));
		ev_flow(ST_CC, 32'h0000_0700, ctl_q & 32'h0000_0700, "power on");
		chk("up pins", {pwr_n, clk_n}, 32'h0);
		for (int i = 0; i < 100 && rst_n !== 1'b1; i++)
			@(posedge core_clk_i);
		repeat (6) @(posedge core_clk_i);
		rd_chk(OFF_LINK_STAT, 32'h1 << BIT_DLL_ACTIVE, 32'h1 << BIT_DLL_ACTIVE, "link");
		cmd(IND_ON, 1'b0, "lamp on");
		chk("lamp on", lamp_n, 32'h0);
	endtask : t_power_up
	task automatic t_power_down;
		cmd(IND_BLINK, 1'b0, "blink down");
		cmd(IND_BLINK, 1'b1, "power off");
		chk("down pins", {pwr_n, clk_n, rst_n}, 32'h0000_0006);
		cmd(IND_OFF, 1'b1, "lamp off");
		chk("lamp off", lamp_n, 32'h1);
		pins(1'b1, 1'b0, 1'b0);
		ev_flow(ST_MRLC, 32'h1 << ST_MRLS, 32'h1 << ST_MRLS, "latch open");
		pins(1'b0, 1'b0, 1'b0);
		ev_flow(ST_PDC, 32'h1 << ST_PDS, 32'h0, "remove");
	endtask : t_power_down
	// mid-run reset as an upstream port: slot logic stays inert
	task automatic t_upstream;
		int a;
		a = as_cnt;
		@(posedge core_clk_i);
		sys_rst_i <= 1'b1;
		down <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		chk("pins rerun", {pwr_n, clk_n, rst_n, lamp_n}, 32'h0000_000D);
		wr(OFF_SLOT, EN | (32'(IND_ON) << CT_IND_LO));
		pins(1'b1, 1'b1, 1'b0);
		repeat (2 * T_DEB) @(posedge core_clk_i);
		chk("upstream int", as_cnt, a);
		rd_chk(OFF_SLOT, 32'h005D_0700, 32'h0040_0400, "upstream");
		chk("upstream power", pwr_n, 32'h1);
	endtask : t_upstream
	task automatic end_of_test;
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (20000) @(posedge core_clk_i);
		fail_count++;
		end_of_test();
	end
	initial
	begin
		repeat (16) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		t_reset();
		t_insert();
		t_latch();
		t_button();
		t_power_up();
		t_power_down();
		t_upstream();
		end_of_test();
	end
endmodule : shc_top_tb
bind shc_top shc_top_assertions #(.TPEPV_CYC(TPEPV_CYC), .STEP_CYC(STEP_CYC)) u_chk (
	.core_clk_i(core_clk_i),
	.sys_rst_i(sys_rst_i),
	.reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.link_active_i(link_active_i),
	.slot_power_on_n_o(slot_power_on_n_o),
	.slot_refclk_on_n_o(slot_refclk_on_n_o),
	.slot_reset_n_o(slot_reset_n_o),
	.intx_assert_o(intx_assert_o)
);
